// [verilog/usr_regs.v]
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "usr_consts.vh"
module usr_regs (
    clk,
    reset,
    addr,
    wdata,
    wr,
    rd,
    rdata,
    rx_start_detect,
    rx_idle_detect,
    rx_char_valid,
    rx_char_data,
    rx_char_noise,
    rx_char_framing,
    rx_char_parity,
    tx_word,
    tx_word_valid,
    tx_word_taken,
    tx_shifter_idle,
    tx_serial,
    rxd_pin,
    txd_pin_in,
    txd_pin_out,
    txd_pin_oe_n,
    rx_serial,
    nine_bit_mode,
    error_irq
);
    input  wire [`USR_ADDR_W-1:0] addr;
    input  wire                   clk;
    input  wire                   reset;
    input  wire [`USR_DATA_W-1:0] wdata;
    input  wire                   wr;
    input  wire                   rd;
    output reg  [`USR_DATA_W-1:0] rdata;
    input  wire                   rx_start_detect;
    input  wire                   rx_idle_detect;
    input  wire                   rx_char_valid;
    input  wire [8:0]             rx_char_data;
    input  wire                   rx_char_noise;
    input  wire                   rx_char_framing;
    input  wire                   rx_char_parity;
    output reg  [8:0]             tx_word;
    output wire                   tx_word_valid;
    input  wire                   tx_word_taken;
    input  wire                   tx_shifter_idle;
    input  wire                   tx_serial;
    input  wire                   rxd_pin;
    input  wire                   txd_pin_in;
    output wire                   txd_pin_out;
    output wire                   txd_pin_oe_n;
    output wire                   rx_serial;
    output wire                   nine_bit_mode;
    output wire                   error_irq;

    // control register fields
    reg                           tx_ninth_bit;
    reg                           single_wire_pin_direction;
    reg                           overrun_irq_enable;
    reg                           noise_irq_enable;
    reg                           framing_irq_enable;
    reg                           parity_irq_enable;

    // mode register fields
    reg                           nine_bit_sel;
    reg                           loopback_select;
    reg                           receiver_source_select;

    // transmit buffer state
    reg                           tx_full;

    // receive side state
    wire [7:0]                    rx_data;
    wire                          rx_ninth_bit;
    wire [`USR_RX_FLAGS_W-1:0]    rx_flags;
    wire                          receiver_active_flag;

    // decoded accesses
    wire                          status_read;
    wire                          data_read;
    wire                          data_write;
    wire                          ctrl_write;
    wire                          mode_write;

    // single-wire steering
    wire                          single_wire;
    wire                          pin_driven;

    // assembled read values
    reg  [`USR_DATA_W-1:0]        next_rdata;
    wire [`USR_DATA_W-1:0]        status_one_value;
    wire [`USR_DATA_W-1:0]        activity_value;
    wire [`USR_DATA_W-1:0]        ctrl_value;
    wire [`USR_DATA_W-1:0]        mode_value;

    // reset images, so single fields can be picked out of them
    localparam [`USR_DATA_W-1:0]  rst_ctrl = `USR_RST_CTRL;
    localparam [`USR_DATA_W-1:0]  rst_mode = `USR_RST_MODE;

    assign status_read = rd && (addr == `USR_OFS_STATUS_ONE);
    assign data_read   = rd && (addr == `USR_OFS_DATA);
    assign data_write  = wr && (addr == `USR_OFS_DATA);
    assign ctrl_write  = wr && (addr == `USR_OFS_CTRL_NINTH);
    assign mode_write  = wr && (addr == `USR_OFS_MODE);

    usr_rx_flags u_rx_flags (
        .clk                  (clk),
        .reset                (reset),
        .start_detect         (rx_start_detect),
        .idle_detect          (rx_idle_detect),
        .char_valid           (rx_char_valid),
        .char_data            (rx_char_data),
        .char_noise           (rx_char_noise),
        .char_framing         (rx_char_framing),
        .char_parity          (rx_char_parity),
        .status_read          (status_read),
        .data_read            (data_read),
        .rx_data              (rx_data),
        .rx_ninth_bit         (rx_ninth_bit),
        .rx_flags             (rx_flags),
        .receiver_active_flag (receiver_active_flag)
    );

    // control register writes; receive ninth bit is read only
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            tx_ninth_bit              <= rst_ctrl[`USR_C3_TX_NINTH];
            single_wire_pin_direction <= rst_ctrl[`USR_C3_PIN_DIR];
            overrun_irq_enable        <= rst_ctrl[`USR_C3_OVR_IE];
            noise_irq_enable          <= rst_ctrl[`USR_C3_NOISE_IE];
            framing_irq_enable        <= rst_ctrl[`USR_C3_FRAME_IE];
            parity_irq_enable         <= rst_ctrl[`USR_C3_PARITY_IE];
        end else if (ctrl_write) begin
            // held until software rewrites it
            tx_ninth_bit              <= wdata[`USR_C3_TX_NINTH];
            single_wire_pin_direction <= wdata[`USR_C3_PIN_DIR];
            overrun_irq_enable        <= wdata[`USR_C3_OVR_IE];
            noise_irq_enable          <= wdata[`USR_C3_NOISE_IE];
            framing_irq_enable        <= wdata[`USR_C3_FRAME_IE];
            parity_irq_enable         <= wdata[`USR_C3_PARITY_IE];
        end
    end

    // mode register writes
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            nine_bit_sel           <= rst_mode[`USR_MODE_NINE_BIT];
            loopback_select        <= rst_mode[`USR_MODE_LOOPBACK];
            receiver_source_select <= rst_mode[`USR_MODE_RX_SOURCE];
        end else if (mode_write) begin
            nine_bit_sel           <= wdata[`USR_MODE_NINE_BIT];
            loopback_select        <= wdata[`USR_MODE_LOOPBACK];
            receiver_source_select <= wdata[`USR_MODE_RX_SOURCE];
        end
    end

    assign nine_bit_mode = nine_bit_sel;

    // transmit buffer: write only half of the data address
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            tx_word <= {1'b0, `USR_RST_DATA};
            tx_full <= 1'b0;
        end else begin
            if (data_write) begin
                // whole nine-bit value captured at the data write
                tx_word <= {nine_bit_sel & tx_ninth_bit, wdata};
                tx_full <= 1'b1;
            end else if (tx_word_taken) begin
                tx_full <= 1'b0;
            end
        end
    end

    assign tx_word_valid = tx_full;

    // single-wire and loopback routing
    assign single_wire  = loopback_select && receiver_source_select;
    assign pin_driven   = !single_wire || single_wire_pin_direction;
    assign txd_pin_oe_n = !pin_driven;
    assign txd_pin_out  = tx_serial;
    assign rx_serial    = single_wire     ? txd_pin_in :
                          loopback_select ? tx_serial  :
                                            rxd_pin;

    // merged error request
    assign error_irq =
        (rx_flags[`USR_S1_OVERRUN] && overrun_irq_enable) ||
        (rx_flags[`USR_S1_NOISE]   && noise_irq_enable)   ||
        (rx_flags[`USR_S1_FRAMING] && framing_irq_enable) ||
        (rx_flags[`USR_S1_PARITY]  && parity_irq_enable);

    // read values
    assign status_one_value = {!tx_full,
                               tx_shifter_idle && !tx_full,
                               rx_flags};
    assign activity_value   = {{(`USR_DATA_W-1){1'b0}},
                               receiver_active_flag};
    // reading this register clears nothing
    assign ctrl_value       = {nine_bit_sel & rx_ninth_bit,
                               tx_ninth_bit,
                               single_wire_pin_direction,
                               1'b0,
                               overrun_irq_enable,
                               noise_irq_enable,
                               framing_irq_enable,
                               parity_irq_enable};
    assign mode_value       = {5'h00,
                               receiver_source_select,
                               loopback_select,
                               nine_bit_sel};

    always @* begin
        next_rdata = {`USR_DATA_W{1'b0}};
        if (rd) begin
            case (addr)
                `USR_OFS_STATUS_ONE: next_rdata = status_one_value;
                `USR_OFS_ACTIVITY:   next_rdata = activity_value;
                `USR_OFS_CTRL_NINTH: next_rdata = ctrl_value;
                `USR_OFS_DATA:       next_rdata = rx_data;
                `USR_OFS_MODE:       next_rdata = mode_value;
                default:             next_rdata = {`USR_DATA_W{1'b0}};
            endcase
        end
    end

    // read data stand only in the cycle after the strobe;
    // activity register has no write path at all
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata <= {`USR_DATA_W{1'b0}};
        end else begin
            rdata <= next_rdata;
        end
    end
endmodule // usr_regs

// [verilog/usr_consts.vh]
// Notes on behaviour
// - writes to activity status are ignored
// - active flag sets on valid start bit
// - active flag clears itself on idle line
// - ninth received bit shown at control bit 7
// - control bit 6 sent as ninth bit
// - ninth transmit bit holds between data writes
// - single-wire mode lets bit 5 steer pin
// - overrun flag and enable raise request
// - noise flag and enable raise request
// - framing flag and enable raise request
// - parity flag and enable raise request
// - data address splits receive and transmit buffers
// - data reads take part in flag clearing
// - clear needs status read, then data read
// - overrun when buffer full, new character dropped
// - noise flag sets with buffer full flag
// - framing flag sets with buffer full flag
`ifndef USR_CONSTS_VH
`define USR_CONSTS_VH

`define USR_ADDR_W          3
`define USR_DATA_W          8

`define USR_OFS_STATUS_ONE  3'h0
`define USR_OFS_ACTIVITY    3'h1
`define USR_OFS_CTRL_NINTH  3'h2
`define USR_OFS_DATA        3'h3
`define USR_OFS_MODE        3'h4

`define USR_S1_TX_EMPTY     7
`define USR_S1_TX_COMPLETE  6
`define USR_S1_RX_FULL      5
`define USR_S1_IDLE         4
`define USR_S1_OVERRUN      3
`define USR_S1_NOISE        2
`define USR_S1_FRAMING      1
`define USR_S1_PARITY       0
`define USR_RX_FLAGS_W      6

`define USR_S2_ACTIVE       0

`define USR_C3_RX_NINTH     7
`define USR_C3_TX_NINTH     6
`define USR_C3_PIN_DIR      5
`define USR_C3_OVR_IE       3
`define USR_C3_NOISE_IE     2
`define USR_C3_FRAME_IE     1
`define USR_C3_PARITY_IE    0

`define USR_MODE_NINE_BIT   0
`define USR_MODE_LOOPBACK   1
`define USR_MODE_RX_SOURCE  2

`define USR_RST_CTRL        8'h00
`define USR_RST_DATA        8'h00
`define USR_RST_MODE        8'h00

`endif

// [verilog/usr_rx_flags.v]
`timescale 1ns/1ps
`include "usr_consts.vh"
module usr_rx_flags (
    clk,
    reset,
    start_detect,
    idle_detect,
    char_valid,
    char_data,
    char_noise,
    char_framing,
    char_parity,
    status_read,
    data_read,
    rx_data,
    rx_ninth_bit,
    rx_flags,
    receiver_active_flag
);
    input  wire                       clk;
    input  wire                       reset;
    input  wire                       start_detect;
    input  wire                       idle_detect;
    input  wire                       char_valid;
    input  wire [8:0]                 char_data;
    input  wire                       char_noise;
    input  wire                       char_framing;
    input  wire                       char_parity;
    input  wire                       status_read;
    input  wire                       data_read;
    output reg  [7:0]                 rx_data;
    output reg                        rx_ninth_bit;
    output reg  [`USR_RX_FLAGS_W-1:0] rx_flags;
    output reg                        receiver_active_flag;

    reg  [`USR_RX_FLAGS_W-1:0] armed;
    reg  [`USR_RX_FLAGS_W-1:0] next_set;
    reg                        idle_allowed;
    wire [`USR_RX_FLAGS_W-1:0] clear_now;
    wire                       accept;

    assign clear_now = data_read ? armed : {`USR_RX_FLAGS_W{1'b0}};
    assign accept    = char_valid && !rx_flags[`USR_S1_RX_FULL];

    always @* begin
        next_set = {`USR_RX_FLAGS_W{1'b0}};
        if (char_valid && !accept) begin
            next_set[`USR_S1_OVERRUN] = 1'b1;
        end
        if (accept) begin
            next_set[`USR_S1_RX_FULL] = 1'b1;
            next_set[`USR_S1_NOISE]   = char_noise;
            next_set[`USR_S1_FRAMING] = char_framing;
            next_set[`USR_S1_PARITY]  = char_parity;
        end
        if (idle_detect && idle_allowed) begin
            next_set[`USR_S1_IDLE] = 1'b1;
        end
    end

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            rx_flags             <= {`USR_RX_FLAGS_W{1'b0}};
            armed                <= {`USR_RX_FLAGS_W{1'b0}};
            idle_allowed         <= 1'b0;
            rx_data              <= `USR_RST_DATA;
            rx_ninth_bit         <= 1'b0;
            receiver_active_flag <= 1'b0;
        end else begin
            // set wins over a clear in the same cycle
            rx_flags <= (rx_flags & ~clear_now) | next_set;
            if (data_read) begin
                armed <= {`USR_RX_FLAGS_W{1'b0}};
            end else if (status_read) begin
                armed <= rx_flags;
            end
            if (accept) begin
                rx_data      <= char_data[7:0];
                rx_ninth_bit <= char_data[8];
            end
            if (next_set[`USR_S1_RX_FULL]) begin
                idle_allowed <= 1'b1;
            end else if (next_set[`USR_S1_IDLE]) begin
                idle_allowed <= 1'b0;
            end
            if (start_detect) begin
                receiver_active_flag <= 1'b1;
            end else if (idle_detect) begin
                receiver_active_flag <= 1'b0;
            end
        end
    end
endmodule // usr_rx_flags

// [sim/usr_regs_sva.sv]
`timescale 1ns/1ps
`include "usr_consts.vh"
module usr_regs_sva (
    input wire logic       clk,
    input wire logic       reset,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    input wire logic       rx_start_detect,
    input wire logic       rx_idle_detect,
    input wire logic [8:0] tx_word,
    input wire logic       tx_word_valid,
    input wire logic       tx_word_taken,
    input wire logic       txd_pin_in,
    input wire logic       txd_pin_oe_n,
    input wire logic       rx_serial
);
    logic active;
    wire  dwr = wr && addr == `USR_OFS_DATA;
    wire  ard = rd && addr == `USR_OFS_ACTIVITY;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // expected active flag, start wins over idle
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            active <= 1'b0;
        end else if (rx_start_detect) begin
            active <= 1'b1;
        end else if (rx_idle_detect) begin
            active <= 1'b0;
        end
    end
    a_rdata_idle: assert property (
        !$past(rd) |-> rdata == 8'h00) else $error("rdata outside answer");
    a_tx_load: assert property (
        dwr |=> tx_word_valid && tx_word[7:0] == $past(wdata))
        else $error("data write not loaded");
    a_tx_hold: assert property (
        tx_word_valid && !tx_word_taken && !dwr |=>
        tx_word_valid && $stable(tx_word)) else $error("tx word changed");
    a_tx_taken: assert property (
        tx_word_taken && !dwr |=> !tx_word_valid)
        else $error("tx word kept after taken");
    a_tx_fall: assert property (
        $fell(tx_word_valid) |-> $past(tx_word_taken))
        else $error("tx word lost");
    a_act_ro: assert property (
        ard |=> rdata[7:1] == 7'h00) else $error("activity upper bits");
    a_act_flag: assert property (
        ard |=> rdata[0] == $past(active)) else $error("active flag wrong");
    a_wire_in: assert property (
        txd_pin_oe_n |-> rx_serial == txd_pin_in)
        else $error("single wire input not routed");
endmodule // usr_regs_sva
bind usr_regs usr_regs_sva i_usr_regs_sva (
    .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .rx_start_detect(rx_start_detect),
    .rx_idle_detect(rx_idle_detect), .tx_word(tx_word),
    .tx_word_valid(tx_word_valid), .tx_word_taken(tx_word_taken),
    .txd_pin_in(txd_pin_in), .txd_pin_oe_n(txd_pin_oe_n),
    .rx_serial(rx_serial));

// [sim/usr_remote_model.sv]
`timescale 1ns/1ps
module usr_remote_model (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic [3:0] slow,
    input  wire logic       tx_word_valid,
    output logic            rx_start_detect,
    output logic            rx_idle_detect,
    output logic            rx_char_valid,
    output logic [8:0]      rx_char_data,
    output logic [2:0]      rx_err,
    output logic            tx_word_taken,
    output logic            tx_shifter_idle,
    output logic            tx_serial,
    output logic            rxd_pin,
    output logic            txd_pin_in
);
    logic [3:0] cnt;
    initial begin
        {rx_start_detect, rx_idle_detect, rx_char_valid} = 3'b000;
        {rx_char_data, rx_err} = 12'h000;
    end
    assign tx_shifter_idle = !tx_word_valid;
    assign rxd_pin = ~tx_serial;
    // shifter takes a word after slow+1 cycles; rxd_pin and txd_pin_in show the same pattern
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            {cnt, tx_word_taken, tx_serial, txd_pin_in} <= 7'h00;
        end else begin
            tx_serial <= ~tx_serial;
            txd_pin_in <= tx_serial;
            tx_word_taken <= 1'b0;
            if (tx_word_valid && !tx_word_taken) begin
                cnt <= (cnt == slow) ? 4'h0 : cnt + 4'h1;
                tx_word_taken <= (cnt == slow);
            end
        end
    end
    task automatic start_bit();
        @(posedge clk);
        rx_start_detect <= 1'b1;
        @(posedge clk);
        rx_start_detect <= 1'b0;
    endtask
    task automatic idle_line();
        @(posedge clk);
        rx_idle_detect <= 1'b1;
        @(posedge clk);
        rx_idle_detect <= 1'b0;
    endtask
    // err: noise, framing, parity
    task automatic send_char(input logic [8:0] v, input logic [2:0] e);
        start_bit();
        repeat (slow) @(posedge clk);
        rx_char_data <= v;
        rx_err <= e;
        rx_char_valid <= 1'b1;
        @(posedge clk);
        rx_char_valid <= 1'b0;
        rx_char_data <= ~v;
        rx_err <= ~e;
        idle_line();
    endtask
endmodule // usr_remote_model

// [sim/usr_regs_tb.sv]
`timescale 1ns/1ps
`include "usr_consts.vh"
module usr_regs_tb;
    localparam logic [2:0] ofs_st = `USR_OFS_STATUS_ONE;
    localparam logic [2:0] ofs_ctl = `USR_OFS_CTRL_NINTH;
    localparam logic [2:0] ofs_dat = `USR_OFS_DATA;
    logic        clk, reset, wr, rd;
    logic        rd_seen = 1'b0;
    logic [2:0]  addr;
    logic [7:0]  wdata, d, x;
    logic [3:0]  slow;
    logic [15:0] n, rq[$], tq[$];
    int          num_errors = 0, cmp_count = 0, cyc = 0;
    wire  [7:0]  rdata;
    wire  [8:0]  tx_word, ch;
    wire  [2:0]  er;
    wire         sd, idd, cv, tv, tt, tsi, ts, rp, tpi, tpo, oen, rs, nb, irq;
    usr_regs i_usr_regs (.clk(clk), .reset(reset), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .rx_start_detect(sd), .rx_idle_detect(idd), .rx_char_valid(cv),
        .rx_char_data(ch), .rx_char_noise(er[2]), .rx_char_framing(er[1]),
        .rx_char_parity(er[0]), .tx_word(tx_word), .tx_word_valid(tv),
        .tx_word_taken(tt), .tx_shifter_idle(tsi), .tx_serial(ts),
        .rxd_pin(rp), .txd_pin_in(tpi), .txd_pin_out(tpo),
        .txd_pin_oe_n(oen), .rx_serial(rs), .nine_bit_mode(nb),
        .error_irq(irq));
    usr_remote_model i_usr_remote_model (.clk(clk), .reset(reset),
        .slow(slow), .tx_word_valid(tv), .rx_start_detect(sd),
        .rx_idle_detect(idd), .rx_char_valid(cv), .rx_char_data(ch),
        .rx_err(er), .tx_word_taken(tt), .tx_shifter_idle(tsi),
        .tx_serial(ts), .rxd_pin(rp), .txd_pin_in(tpi));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic bus_wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        {addr, wdata, wr} <= {a, v, 1'b1};
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic bus_rd(input logic [2:0] a, input logic [7:0] m, e);
        @(posedge clk);
        {addr, rd} <= {a, 1'b1};
        rq.push_back({m, e});
        @(posedge clk);
        rd <= 1'b0;
    endtask
    task automatic irq_is(input logic e);
        #1;
        chk({15'h0000, irq}, {15'h0000, e});
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        rd_seen <= rd;
        if (rd_seen) begin
            n = rq.pop_front();
            chk({8'h00, rdata & n[15:8]}, {8'h00, n[7:0]});
        end
        if (tt) chk({7'h00, tx_word}, tq.pop_front());
        if (cyc == 20000) begin
            num_errors++;
            give_verdict();
        end
    end
    initial begin
        {reset, wr, rd, addr, wdata, slow} <= {3'b100, 3'h0, 8'h00, 4'h0};
        void'($urandom(96498));
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        for (int a = 0; a < 8; a++) begin
            bus_rd(a[2:0], 8'hff, (a == 0) ? 8'hc0 : 8'h00);
        end
        bus_wr(`USR_OFS_ACTIVITY, 8'hff);
        bus_wr(ofs_st, 8'hff);
        bus_rd(`USR_OFS_ACTIVITY, 8'hff, 8'h00);
        bus_rd(ofs_st, 8'hff, 8'hc0);
        i_usr_remote_model.start_bit();
        bus_rd(`USR_OFS_ACTIVITY, 8'hff, 8'h01);
        i_usr_remote_model.idle_line();
        bus_rd(`USR_OFS_ACTIVITY, 8'hff, 8'h00);
        $display("test reset, read-only and activity done");
        bus_wr(`USR_OFS_MODE, 8'h01);
        i_usr_remote_model.send_char(9'h1a5, 3'b100);
        bus_rd(ofs_dat, 8'hff, 8'ha5);
        bus_rd(ofs_st, 8'h2f, 8'h24);
        bus_rd(ofs_ctl, 8'h80, 8'h80);
        bus_rd(ofs_dat, 8'hff, 8'ha5);
        bus_rd(ofs_st, 8'h2f, 8'h00);
        for (int k = 0; k < 3; k++) begin
            d = 8'($urandom);
            i_usr_remote_model.send_char({1'b0, d}, 3'(1 << k));
            bus_wr(ofs_ctl, ~(8'h01 << k) & 8'h0f);
            irq_is(1'b0);
            bus_wr(ofs_ctl, 8'h01 << k);
            irq_is(1'b1);
            bus_rd(ofs_st, 8'h2f, 8'h20 | (8'h01 << k));
            bus_rd(ofs_dat, 8'hff, d);
            irq_is(1'b0);
        end
        x = 8'($urandom);
        i_usr_remote_model.send_char({1'b0, x}, 3'b000);
        i_usr_remote_model.send_char(9'h1ff, 3'b111);
        bus_wr(ofs_ctl, 8'h08);
        irq_is(1'b1);
        bus_rd(ofs_st, 8'h2f, 8'h28);
        bus_rd(ofs_dat, 8'hff, x);
        irq_is(1'b0);
        $display("test receive, flags and requests done");
        bus_wr(ofs_ctl, 8'h40);
        for (int i = 0; i < 4; i++) begin
            d = 8'($urandom);
            slow <= 4'(i * 3);
            if (i == 3) bus_wr(`USR_OFS_MODE, 8'h00);
            tq.push_back({7'h00, i < 3, d});
            bus_wr(ofs_dat, d);
            #1;
            repeat (40) if (tv) @(posedge clk);
        end
        bus_rd(ofs_dat, 8'hff, x);
        $display("test transmit done");
        bus_wr(`USR_OFS_MODE, 8'h07);
        bus_wr(ofs_ctl, 8'h00);
        #1;
        chk({13'h0, nb, oen, rs}, {13'h0, 1'b1, 1'b1, tpi});
        bus_wr(ofs_ctl, 8'h20);
        #1;
        chk({14'h0000, oen, tpo}, {14'h0000, 1'b0, ts});
        bus_wr(`USR_OFS_MODE, 8'h02);
        #1;
        chk({14'h0000, nb, rs}, {14'h0000, 1'b0, ts});
        bus_wr(`USR_OFS_MODE, 8'h00);
        #1;
        chk({14'h0000, oen, rs}, {14'h0000, 1'b0, rp});
        $display("test pin direction done");
        repeat (10) @(posedge clk);
        give_verdict();
    end
endmodule // usr_regs_tb
